/* File: verilog/sync_serial_cfg.svh */
/*
  Constants of the 8-bit synchronous serial transceiver: register indices,
  field positions, reset values, clock divider half periods and bus answers.
  Assumes it is included by bare name from the package and the design file.
*/
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH

// register indices; byte address on the bus is four times the index
`define IDX_TRIGGER 10'h2E7
`define IDX_PORT_ONE 10'h2EC
`define IDX_DATA_LO 10'h2F0
`define IDX_DATA_HI 10'h2F1
`define IDX_CONTROL 10'h2F2
`define IDX_FLAG 10'h2F3

// field positions
`define BIT_TRIGGER 3
`define BIT_BUSY 1
`define BIT_FLAG 0
`define BIT_CS_HI 3
`define BIT_CS_LO 2
`define BIT_EDGE 1
`define BIT_IEN 0

// reset values
`define CS_RESET 2'b11
`define EDGE_RESET 1'b0
`define IEN_RESET 1'b0

// clock select encodings
`define CS_DIV1 2'b00
`define CS_DIV2 2'b01
`define CS_DIV4 2'b10
`define CS_SLAVE 2'b11

// aclk cycles per half period of the master serial clock
`define HALF_DIV1 3'h1
`define HALF_DIV2 3'h2
`define HALF_DIV4 3'h4

// bits per transfer, last bit index
`define LAST_BIT 3'h7

// bus answers
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

/* File: verilog/sync_serial_pkg.sv */
/*
  Types of the 8-bit synchronous serial transceiver.
  Assumes the constants header is on the include path.
*/
package sync_serial_pkg;
  `include "sync_serial_cfg.svh"

  // transfer engine states
  typedef enum logic {
    st_idle,
    st_run
  } xfer_state_e;

  // software control fields
  typedef struct packed {
    logic [1:0] clock_select;
    logic edge_select;
    logic completion_irq_enable;
  } control_s;

  // per-cycle serial clock events, internal uninverted sense
  typedef struct packed {
    logic rise;
    logic fall;
  } sclk_event_s;
endpackage

/* File: verilog/sync_serial.sv */
/*
  8-bit synchronous serial transceiver, master or slave, with an AXI4-Lite
  register slave. Assumes one clock aclk, synchronous active-low reset, and
  pin inputs already synchronous to aclk.
*/
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"

module sync_serial
  import sync_serial_pkg::*;
#(
  parameter bit MSB_FIRST = 1'b0,
  parameter bit SCLK_INVERT = 1'b0,
  parameter bit BUSY_ON_PORT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  output logic general_out_port_one,
  output logic completion_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  control_s control;
  xfer_state_e state;
  logic [7:0] shifter;
  logic [2:0] bit_count;
  logic [2:0] half_count;
  logic int_clk;
  logic prev_level;
  logic completion_flag;
  logic port_latch;
  logic [11:0] aw_addr_held;
  logic aw_held;
  logic [31:0] w_data_held;
  logic [3:0] w_strb_held;
  logic w_held;

  logic do_write;
  logic do_read;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic wr_lane0;
  logic trigger_write;
  logic flag_read;
  logic is_master;
  logic busy_status;
  logic [2:0] half_limit;
  logic pin_level;
  sclk_event_s ev;
  logic sample_edge;
  logic last_fall;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // a write fires once address and data are both held and no answer waits
  assign do_write = aw_held && w_held && !bvalid;
  assign do_read = arvalid && arready;
  assign wr_idx = aw_addr_held[11:2];
  assign rd_idx = araddr[11:2];
  assign wr_lane0 = w_strb_held[0];
  assign trigger_write = do_write && wr_lane0 && (wr_idx == `IDX_TRIGGER)
    && w_data_held[`BIT_TRIGGER];
  assign flag_read = do_read && (rd_idx == `IDX_FLAG);
  assign is_master = (control.clock_select != `CS_SLAVE);
  assign busy_status = (state == st_run);

  ////////////////////////////////////////////////////////////////////////////
  // serial clock events

  // half period per clock select
  always_comb begin
    case (control.clock_select)
      `CS_DIV1: half_limit = `HALF_DIV1;
      `CS_DIV2: half_limit = `HALF_DIV2;
      `CS_DIV4: half_limit = `HALF_DIV4;
      default: half_limit = `HALF_DIV1;
    endcase
  end

  // pin level in internal sense; inputs are synchronous, no synchroniser
  assign pin_level = sclk_in ^ SCLK_INVERT;

  // edges of the internal clock, from the divider or the pin
  always_comb begin
    ev = '0;
    if (busy_status) begin
      if (is_master) begin
        if (half_count == half_limit - 3'h1) begin
          ev.rise = !int_clk;
          ev.fall = int_clk;
        end
      end else begin
        ev.rise = pin_level && !prev_level;
        ev.fall = !pin_level && prev_level;
      end
    end
  end

  assign sample_edge = control.edge_select ? ev.rise : ev.fall;
  // a transfer ends at the falling edge closing the eighth clock
  assign last_fall = ev.fall && (bit_count == `LAST_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // transfer engine

  // run/idle; a second trigger while running keeps the state but restarts the clock count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (trigger_write) begin
            state <= st_run;
          end
        end
        st_run: begin
          if (flag_read || last_fall) begin
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // clock count; cleared on every trigger and on abort
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_count <= 3'h0;
    end else if (trigger_write || flag_read || !busy_status) begin
      bit_count <= 3'h0;
    end else if (ev.fall) begin
      bit_count <= bit_count + 3'h1;
    end
  end

  // synchronous divider; the clock rests low whenever idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_count <= 3'h0;
      int_clk <= 1'b0;
    end else if (!busy_status || !is_master || flag_read || last_fall) begin
      half_count <= 3'h0;
      int_clk <= 1'b0;
    end else if (ev.rise || ev.fall) begin
      half_count <= 3'h0;
      int_clk <= ev.rise;
    end else begin
      half_count <= half_count + 3'h1;
    end
  end

  // previous pin level for slave edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= pin_level;
    end
  end

  // one shifter for both directions; software nibble writes load it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shifter <= 8'h00;
    end else if (sample_edge) begin
      if (MSB_FIRST) begin
        shifter <= {shifter[6:0], serial_in_pin};
      end else begin
        shifter <= {serial_in_pin, shifter[7:1]};
      end
    end else if (do_write && wr_lane0 && !busy_status) begin
      // data writes during a run would corrupt the byte in flight
      if (wr_idx == `IDX_DATA_LO) begin
        shifter[3:0] <= w_data_held[3:0];
      end else if (wr_idx == `IDX_DATA_HI) begin
        shifter[7:4] <= w_data_held[3:0];
      end
    end
  end

  // output bit moves only on the rising edge, whatever the sample edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_out_pin <= 1'b0;
    end else if (ev.rise) begin
      serial_out_pin <= MSB_FIRST ? shifter[7] : shifter[0];
    end
  end

  // clock pin drive, polarity applied at the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_out <= SCLK_INVERT;
      sclk_oe <= 1'b0;
    end else begin
      sclk_oe <= is_master;
      if (!busy_status || !is_master || flag_read || last_fall) begin
        sclk_out <= SCLK_INVERT;
      end else if (ev.rise || ev.fall) begin
        sclk_out <= ev.rise ^ SCLK_INVERT;
      end
    end
  end

  // completion flag: a completion in the read cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      completion_flag <= 1'b0;
    end else if (last_fall && busy_status) begin
      completion_flag <= 1'b1;
    end else if (flag_read) begin
      completion_flag <= 1'b0;
    end
  end

  // interrupt request gated by the enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      completion_irq <= 1'b0;
    end else begin
      completion_irq <= completion_flag && control.completion_irq_enable;
    end
  end

  // general output pin carries busy or a plain software latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_latch <= 1'b0;
      general_out_port_one <= 1'b0;
    end else begin
      if (do_write && wr_lane0 && wr_idx == `IDX_PORT_ONE) begin
        port_latch <= w_data_held[`BIT_BUSY];
      end
      general_out_port_one <= BUSY_ON_PORT ? (busy_status || trigger_write)
        : port_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control.clock_select <= `CS_RESET;
      control.edge_select <= `EDGE_RESET;
      control.completion_irq_enable <= `IEN_RESET;
    end else if (do_write && wr_lane0 && wr_idx == `IDX_CONTROL) begin
      control.clock_select <= w_data_held[`BIT_CS_HI:`BIT_CS_LO];
      control.edge_select <= w_data_held[`BIT_EDGE];
      control.completion_irq_enable <= w_data_held[`BIT_IEN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus write channel

  // address and data are taken in either order and held until used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_held <= 12'h000;
      awready <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_held <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      awready <= !aw_held && !(awvalid && awready) && !bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_held <= 32'h00000000;
      w_strb_held <= 4'h0;
      wready <= 1'b0;
    end else begin
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_held <= wdata;
        w_strb_held <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      wready <= !w_held && !(wvalid && wready) && !bvalid;
    end
  end

  // write answer; unmapped indices get a decode error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      case (wr_idx)
        `IDX_TRIGGER, `IDX_PORT_ONE, `IDX_DATA_LO, `IDX_DATA_HI, `IDX_CONTROL,
        `IDX_FLAG: bresp <= `RESP_OKAY;
        default: bresp <= `RESP_DECERR;
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read channel

  // one read at a time; data and side effects come with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else begin
      arready <= !rvalid && !do_read;
      if (do_read) begin
        rvalid <= 1'b1;
        rdata <= 32'h00000000;
        rresp <= `RESP_OKAY;
        case (rd_idx)
          `IDX_TRIGGER: rdata <= 32'h00000000; // trigger reads zero
          `IDX_PORT_ONE: rdata[`BIT_BUSY] <= BUSY_ON_PORT ? busy_status
            : port_latch;
          `IDX_DATA_LO: rdata[3:0] <= shifter[3:0];
          `IDX_DATA_HI: rdata[3:0] <= shifter[7:4];
          `IDX_CONTROL: begin
            rdata[`BIT_CS_HI:`BIT_CS_LO] <= control.clock_select;
            rdata[`BIT_EDGE] <= control.edge_select;
            rdata[`BIT_IEN] <= control.completion_irq_enable;
          end
          `IDX_FLAG: rdata[`BIT_FLAG] <= completion_flag;
          default: rresp <= `RESP_DECERR;
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: test/sync_serial_props.sv */
/*
  Port checker of the serial transceiver.
  Assumes the busy state is mirrored on the port pin (default build).
*/
`timescale 1ns/1ps
module sync_serial_props
  import sync_serial_pkg::*;
#(
  parameter bit SCLK_INVERT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic serial_out_pin,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic general_out_port_one
);
  logic k_q;
  logic [3:0] pcnt;
  logic [7:0] blen;
  wire logic k = sclk_out ^ SCLK_INVERT;
  wire logic busy = general_out_port_one;

  ////////////////////////////////////////
  // previous internal clock level
  always_ff @(posedge aclk) begin
    k_q <= k;
  end

  // pulses and cycles of the current run, cleared while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn || !busy) begin
      pcnt <= 4'h0;
      blen <= 8'h00;
    end else begin
      pcnt <= pcnt + {3'h0, k && !k_q};
      blen <= blen + 8'h01;
    end
  end

  ////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_idle;
    $rose(aresetn) |-> !sclk_oe && sclk_out == SCLK_INVERT;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("clock pin not idle after reset");

  property p_clk_idle;
    !busy && !$past(busy) |-> sclk_out == SCLK_INVERT;
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("clock pin moves while stopped");

  property p_pulses;
    $fell(busy) && sclk_oe |-> pcnt == 4'h8;
  endproperty
  a_pulses: assert property (p_pulses)
    else $error("master run did not emit eight pulses");

  property p_pulse_max;
    pcnt <= 4'h8;
  endproperty
  a_pulse_max: assert property (p_pulse_max)
    else $error("more than eight pulses");

  property p_run_len;
    $fell(busy) && sclk_oe |-> blen >= 8'h10 && blen <= 8'h48;
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("master run length off");

  property p_out_edge;
    busy && $past(busy) && sclk_oe && $changed(serial_out_pin) |-> $rose(k);
  endproperty
  a_out_edge: assert property (p_out_edge)
    else $error("data out moved off a rising edge");

  property p_trig;
    awvalid && awready && wvalid && wready && awaddr == 12'hB9C && wdata[3]
      |-> ##[1:4] busy;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger did not raise busy");

  property p_bdone;
    bvalid && bready |=> !bvalid;
  endproperty
  a_bdone: assert property (p_bdone)
    else $error("write answer repeated");

  property p_rdone;
    rvalid && rready |=> !rvalid;
  endproperty
  a_rdone: assert property (p_rdone)
    else $error("read answer repeated");
endmodule

bind sync_serial sync_serial_props #(.SCLK_INVERT(SCLK_INVERT)) props_u (
  .aclk(aclk),
  .aresetn(aresetn),
  .awaddr(awaddr),
  .awvalid(awvalid),
  .awready(awready),
  .wdata(wdata),
  .wvalid(wvalid),
  .wready(wready),
  .bvalid(bvalid),
  .bready(bready),
  .rvalid(rvalid),
  .rready(rready),
  .serial_out_pin(serial_out_pin),
  .sclk_out(sclk_out),
  .sclk_oe(sclk_oe),
  .general_out_port_one(general_out_port_one)
);

/* File: test/serial_peer.sv */
/*
  Far-side serial device: slave paced by the block, or master driving it.
  Assumes pins synchronous to aclk, lsb first, uninverted clock pin.
*/
`timescale 1ns/1ps
module serial_peer #(
  parameter bit INV = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic lead,
  input wire logic smp,
  input wire logic [3:0] npulse,
  input wire logic [7:0] tx,
  input wire logic sclk_out,
  input wire logic serial_out_pin,
  output logic sclk_in,
  output logic serial_in_pin,
  output logic [7:0] rx,
  output logic done
);
  logic k_q;
  logic pin_q;
  logic [7:0] sh;
  logic [2:0] ph;
  logic [3:0] n;
  wire logic k = sclk_out ^ INV;
  wire logic ev = smp ? (!k && k_q) : (k && !k_q);

  // fast slave: next bit shows in the very cycle of the launch edge
  assign serial_in_pin = (go && !lead) ? (ev ? sh[1] : sh[0]) : pin_q;

  always_ff @(posedge aclk) begin
    k_q <= k;
  end

  // idle line wanders so no stale bit passes for data
  always_ff @(posedge aclk) begin
    if (!aresetn || !go) begin
      sh <= (smp || lead) ? tx : {tx[6:0], tx[7]};
      n <= 4'h0;
      ph <= 3'h6;
      done <= 1'b0;
      sclk_in <= INV;
      pin_q <= aresetn && !pin_q;
    end else if (!lead) begin
      if (ev) sh <= {sh[0], sh[7:1]};
      if (!k && k_q) rx <= {serial_out_pin, rx[7:1]};
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h6) begin
        pin_q <= sh[0];
        sh <= {sh[0], sh[7:1]};
      end
      if (ph == 3'h0 && n != npulse) sclk_in <= !INV;
      if (ph == 3'h0 && n == npulse) done <= 1'b1;
      if (ph == 3'h3 && n < 4'h8) rx <= {serial_out_pin, rx[7:1]};
      if (ph == 3'h4 && n != npulse) begin
        sclk_in <= INV;
        n <= n + 4'h1;
      end
    end
  end
endmodule

/* File: test/test_sync_serial.sv */
/*
  Bench of the serial transceiver: register tasks over the bus, transfers
  against the far-side model. Assumes default build options.
*/
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
module test_sync_serial;
  `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF, npulse = 4'hA, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, serial_out_pin;
  logic sclk_out, sclk_oe, general_out_port_one, completion_irq;
  logic sclk_in, serial_in_pin, done, go = 0, lead = 0, smp = 0;
  logic [1:0] bresp, rresp, r;
  logic [7:0] tx = 8'h00, rx;
  int n_fail = 0;
  int tests_run = 0;

  sync_serial dut_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin),
    .sclk_in(sclk_in),
    .sclk_out(sclk_out),
    .sclk_oe(sclk_oe),
    .general_out_port_one(general_out_port_one),
    .completion_irq(completion_irq)
  );
  serial_peer peer_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .go(go),
    .lead(lead),
    .smp(smp),
    .npulse(npulse),
    .tx(tx),
    .sclk_out(sclk_out),
    .serial_out_pin(serial_out_pin),
    .sclk_in(sclk_in),
    .serial_in_pin(serial_in_pin),
    .rx(rx),
    .done(done)
  );

  // fixed rate, never switched mid-run
  always #20 aclk = ~aclk;

  ////////////////////////////////////////
  task automatic wr(input logic [9:0] i, input logic [3:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {28'h0000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      awvalid <= awvalid && !awready;
      wvalid <= wvalid && !wready;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] i, output logic [3:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    v = rdata[3:0];
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [9:0] i, input logic [3:0] e, input logic [3:0] m);
    rd(i, d, r);
    `CHK(d & m, e)
  endtask

  // one whole transfer; slave clock only starts after the trigger
  task automatic xfer(input logic [1:0] cs, input logic e, input logic ien,
                      input logic [7:0] t, input logic [7:0] b);
    tx <= t;
    smp <= e;
    lead <= (cs == `CS_SLAVE);
    wr(`IDX_DATA_LO, b[3:0], r);
    wr(`IDX_DATA_HI, b[7:4], r);
    wr(`IDX_CONTROL, {cs, e, ien}, r);
    go <= (cs != `CS_SLAVE);
    wr(`IDX_TRIGGER, 4'h8, r);
    `CHK(sclk_oe, cs != `CS_SLAVE)
    `CHK(general_out_port_one, 1'b1)
    chk_rd(`IDX_PORT_ONE, 4'h2, 4'h2);
    go <= 1'b1;
    while (lead && !done) @(posedge aclk);
    while (general_out_port_one) @(posedge aclk);
    repeat (2) @(posedge aclk);
    go <= 1'b0;
    `CHK(completion_irq, ien)
    `CHK(rx, b)
    chk_rd(`IDX_DATA_LO, t[3:0], 4'hF);
    chk_rd(`IDX_DATA_HI, t[7:4], 4'hF);
    chk_rd(`IDX_FLAG, 4'h1, 4'h1);
    chk_rd(`IDX_FLAG, 4'h0, 4'h1);
    `CHK(completion_irq, 1'b0)
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(`IDX_CONTROL, 4'hC, 4'hF);
    chk_rd(`IDX_PORT_ONE, 4'h0, 4'h2);
    chk_rd(`IDX_TRIGGER, 4'h0, 4'h8);
    xfer(`CS_DIV1, 1'b0, 1'b1, 8'h96, 8'h3C);
    xfer(`CS_DIV2, 1'b1, 1'b0, 8'h5A, 8'hC3);
    xfer(`CS_DIV4, 1'b0, 1'b0, 8'h0F, 8'hE1);
    xfer(`CS_SLAVE, 1'b1, 1'b1, 8'hA9, 8'h71);
    xfer(`CS_SLAVE, 1'b0, 1'b0, 8'h3E, 8'h85);
    // abort a waiting slave run by reading the flag
    wr(`IDX_TRIGGER, 4'h8, r);
    chk_rd(`IDX_PORT_ONE, 4'h2, 4'h2);
    chk_rd(`IDX_FLAG, 4'h0, 4'h1);
    chk_rd(`IDX_PORT_ONE, 4'h0, 4'h2);
    rd(10'h100, d, r);
    `CHK(r, `RESP_DECERR)
    wr(10'h100, 4'hF, r);
    `CHK(r, `RESP_DECERR)
    wr(`IDX_DATA_LO, 4'h6, r);
    `CHK(r, `RESP_OKAY)
    summarize;
  end

  // hang guard, well beyond the several hundred cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    summarize;
  end
endmodule
